/* File: shared/ddc_regs_pkg.sv */
// Package: offsets, field positions, reset values and carriers for the tuning and format bank
package ddc_regs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame layout: read flag, address, data, most significant bit first
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int HEAD_W = 1 + ADDR_W;
  localparam logic [4:0] HEAD_LAST = 5'h0F;
  localparam logic [4:0] DATA_LAST = 5'h07;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [ADDR_W-1:0] SOFT_RESET_OFS = 15'h0000;
  localparam logic [ADDR_W-1:0] TUNE_B0_OFS = 15'h0031;
  localparam logic [ADDR_W-1:0] TUNE_B1_OFS = 15'h0032;
  localparam logic [ADDR_W-1:0] TUNE_B2_OFS = 15'h0033;
  localparam logic [ADDR_W-1:0] TUNE_B3_OFS = 15'h0034;
  localparam logic [ADDR_W-1:0] CODING_A_OFS = 15'h008F;
  localparam logic [ADDR_W-1:0] CODING_B_OFS = 15'h0092;

  // Register slots in the bank, in this order
  localparam int NUM_REGS = 6;
  localparam int CODING_A_IDX = 4;
  localparam int CODING_B_IDX = 5;
  localparam logic [NUM_REGS-1:0][ADDR_W-1:0] REG_OFS = {
    CODING_B_OFS, CODING_A_OFS, TUNE_B3_OFS, TUNE_B2_OFS, TUNE_B1_OFS, TUNE_B0_OFS
  };

  ////////////////////////////////////////////////////////////////////////////
  // Fields and reset values
  localparam int SOFT_RESET_BIT = 0;
  localparam int CODING_SEL_BIT = 1;
  localparam logic [DATA_W-1:0] TUNE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CODING_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic rd;
    logic [ADDR_W-1:0] addr;
  } spi_head_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } reg_write_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HEAD = 2'b01,
    ST_DATA = 2'b10,
    ST_DONE = 2'b11
  } spi_state_e;

endpackage

/* File: hdl/cfg_byte_reg.sv */
// One byte-wide configuration register with write, clear and reset
`timescale 1ns/10ps
module cfg_byte_reg
  import ddc_regs_pkg::*;
#(
  parameter logic [DATA_W-1:0] RESET_VAL = 8'h00
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clr,
  input wire logic we,
  input wire logic [DATA_W-1:0] d,
  output logic [DATA_W-1:0] q
);

  // Clear wins over a write in the same cycle
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= RESET_VAL;
    end
    else if (clr)
    begin
      q <= RESET_VAL;
    end
    else if (we)
    begin
      q <= d;
    end
  end

endmodule

/* File: hdl/ddc_tuning_format_regs.sv */
// Tuning word and output coding registers behind the serial control port
`timescale 1ns/10ps
module ddc_tuning_format_regs
  import ddc_regs_pkg::*;
#(
  parameter int SAMPLE_W = 18
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sen_n,
  input wire logic sclk,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  input wire logic real_decim,
  input wire logic [SAMPLE_W-1:0] sample_a_in,
  input wire logic [SAMPLE_W-1:0] sample_b_in,
  output logic [31:0] chan_b_tuning_word,
  output logic chan_a_offset_bin,
  output logic chan_b_offset_bin,
  output logic [SAMPLE_W-1:0] sample_a_out,
  output logic [SAMPLE_W-1:0] sample_b_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Serial port edge detection; pins are synchronous to ref_clk
  logic sclk_q;
  logic sclk_rise;
  logic sclk_fall;
  spi_state_e state_q;
  logic [4:0] cnt_q;
  logic [HEAD_W-1:0] head_shift_q;
  logic [DATA_W-1:0] data_shift_q;
  logic [DATA_W-1:0] rd_shift_q;
  spi_head_s head_q;
  spi_head_s head_next;
  logic wr_stb_q;
  reg_write_s wr_q;
  logic soft_rst_q;
  logic sdio_out_q;
  logic sdio_oe_q;
  logic [NUM_REGS-1:0][DATA_W-1:0] reg_val;
  logic [DATA_W-1:0] rd_data;

  assign sclk_rise = sclk & ~sclk_q & ~sen_n;
  assign sclk_fall = ~sclk & sclk_q & ~sen_n;
  assign head_next = spi_head_s'({head_shift_q[HEAD_W-2:0], sdio_in});

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_q <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer; a frame ends only when the select pin rises
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
    end
    else if (sen_n)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          state_q <= ST_HEAD;
          cnt_q <= 5'h00;
        end
        ST_HEAD:
        begin
          if (sclk_rise)
          begin
            if (cnt_q == HEAD_LAST)
            begin
              state_q <= ST_DATA;
              cnt_q <= 5'h00;
            end
            else
            begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
        end
        ST_DATA:
        begin
          if (sclk_rise)
          begin
            if (cnt_q == DATA_LAST)
            begin
              state_q <= ST_DONE;
            end
            else
            begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
        end
        default:
        begin
          // Extra clocks after the data byte are ignored
          state_q <= ST_DONE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift registers for header and write data
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      head_shift_q <= '0;
      head_q <= '0;
      data_shift_q <= 8'h00;
    end
    else if (sclk_rise && (state_q == ST_HEAD))
    begin
      head_shift_q <= head_next;
      if (cnt_q == HEAD_LAST)
      begin
        head_q <= head_next;
      end
    end
    else if (sclk_rise && (state_q == ST_DATA))
    begin
      data_shift_q <= {data_shift_q[DATA_W-2:0], sdio_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write strobe, one cycle after the last data bit
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_stb_q <= 1'b0;
      wr_q <= '0;
    end
    else
    begin
      wr_stb_q <= sclk_rise && (state_q == ST_DATA) && (cnt_q == DATA_LAST) && !head_q.rd;
      if (sclk_rise && (state_q == ST_DATA) && (cnt_q == DATA_LAST))
      begin
        wr_q <= '{addr: head_q.addr, data: {data_shift_q[DATA_W-2:0], sdio_in}};
      end
    end
  end

  // Software reset self-clears: it is a one-cycle pulse and reads back as zero
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      soft_rst_q <= 1'b0;
    end
    else
    begin
      soft_rst_q <= wr_stb_q && (wr_q.addr == SOFT_RESET_OFS) && wr_q.data[SOFT_RESET_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: byte is latched with the header and driven out on falling edges
  always_comb
  begin
    rd_data = UNMAPPED_READ;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      if (head_next.addr == REG_OFS[i])
      begin
        rd_data = reg_val[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_shift_q <= 8'h00;
      sdio_out_q <= 1'b0;
      sdio_oe_q <= 1'b0;
    end
    else if (sen_n)
    begin
      sdio_out_q <= 1'b0;
      sdio_oe_q <= 1'b0;
    end
    else if (sclk_rise && (state_q == ST_HEAD) && (cnt_q == HEAD_LAST))
    begin
      rd_shift_q <= rd_data;
      sdio_oe_q <= head_next.rd;
    end
    else if (sclk_fall && (state_q == ST_DATA) && head_q.rd)
    begin
      sdio_out_q <= rd_shift_q[DATA_W-1];
      rd_shift_q <= {rd_shift_q[DATA_W-2:0], 1'b0};
    end
    else if (state_q == ST_DONE)
    begin
      sdio_oe_q <= 1'b0;
    end
  end

  assign sdio_out = sdio_out_q;
  assign sdio_oe = sdio_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register bank
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++)
    begin : g_reg
      localparam bit IS_TUNE = (g < CODING_A_IDX);
      logic we;
      logic clr;
      // Real decimation holds the tuning bytes at zero and blocks writes to them
      assign we = wr_stb_q && (wr_q.addr == REG_OFS[g]) && !(IS_TUNE && real_decim);
      assign clr = soft_rst_q || (IS_TUNE && real_decim);
      cfg_byte_reg #(
        .RESET_VAL(IS_TUNE ? TUNE_RESET : CODING_RESET)
      ) u_reg (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clr(clr),
        .we(we),
        .d(wr_q.data),
        .q(reg_val[g])
      );
    end
  endgenerate

  // Reserved format bits are stored as written; software keeps them zero
  assign chan_b_tuning_word = {reg_val[3], reg_val[2], reg_val[1], reg_val[0]};
  assign chan_a_offset_bin = reg_val[CODING_A_IDX][CODING_SEL_BIT];
  assign chan_b_offset_bin = reg_val[CODING_B_IDX][CODING_SEL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Output coding: offset binary is two's complement with the sign bit flipped
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sample_a_out <= '0;
      sample_b_out <= '0;
    end
    else
    begin
      sample_a_out <= {sample_a_in[SAMPLE_W-1] ^ chan_a_offset_bin,
                       sample_a_in[SAMPLE_W-2:0]};
      sample_b_out <= {sample_b_in[SAMPLE_W-1] ^ chan_b_offset_bin,
                       sample_b_in[SAMPLE_W-2:0]};
    end
  end

endmodule

/* File: tb/regs_chk.sv */
// Checker for the tuning word and output coding bank
`timescale 1ns/10ps
module regs_chk
  import ddc_regs_pkg::*;
#(
  parameter int SAMPLE_W = 18
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sen_n,
  input wire logic real_decim,
  input wire logic [SAMPLE_W-1:0] sample_a_in,
  input wire logic [SAMPLE_W-1:0] sample_b_in,
  input wire logic [SAMPLE_W-1:0] sample_a_out,
  input wire logic [SAMPLE_W-1:0] sample_b_out,
  input wire logic [31:0] chan_b_tuning_word,
  input wire logic chan_a_offset_bin,
  input wire logic chan_b_offset_bin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  // Register changes only follow a frame or a real-mode clear
  property p_word;
    $changed(chan_b_tuning_word) |-> real_decim || $past(real_decim) || !$past(sen_n)
      || !$past(sen_n, 2) || !$past(sen_n, 3);
  endproperty
  a_word: assert property (p_word) else $error("tuning word changed");
  property p_zero;
    real_decim |=> chan_b_tuning_word == 32'h00000000;
  endproperty
  a_zero: assert property (p_zero) else $error("tuning word not zero");
  property p_bits;
    $changed({chan_a_offset_bin, chan_b_offset_bin}) |-> !$past(sen_n) || !$past(sen_n, 2)
      || !$past(sen_n, 3);
  endproperty
  a_bits: assert property (p_bits) else $error("coding bit changed");
  // Armed one cycle late: the first edge after reset release may not capture
  property p_samp_a;
    $past(resetn) |=> sample_a_out == ($past(sample_a_in)
      ^ {$past(chan_a_offset_bin), {(SAMPLE_W-1){1'b0}}});
  endproperty
  a_samp_a: assert property (p_samp_a) else $error("channel a coding");
  property p_samp_b;
    $past(resetn) |=> sample_b_out == ($past(sample_b_in)
      ^ {$past(chan_b_offset_bin), {(SAMPLE_W-1){1'b0}}});
  endproperty
  a_samp_b: assert property (p_samp_b) else $error("channel b coding");
  c_a: cover property ($rose(chan_a_offset_bin));
  c_b: cover property ($rose(chan_b_offset_bin));
  c_r: cover property ($fell(real_decim));
endmodule
bind ddc_tuning_format_regs regs_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.ref_clk(ref_clk),
  .resetn(resetn), .sen_n(sen_n), .real_decim(real_decim), .sample_a_in(sample_a_in),
  .sample_b_in(sample_b_in), .sample_a_out(sample_a_out), .sample_b_out(sample_b_out),
  .chan_b_tuning_word(chan_b_tuning_word), .chan_a_offset_bin(chan_a_offset_bin),
  .chan_b_offset_bin(chan_b_offset_bin));

/* File: tb/tb.sv */
// Self-checking bench for the tuning word and output coding bank
`timescale 1ns/10ps
module tb
  import ddc_regs_pkg::*;
  ;
  logic ref_clk = 0, resetn = 0, sen_n = 1, sclk = 0, mosi = 0, real_decim = 0;
  logic [17:0] sa = 0, sb = 0;
  logic sdio_out, sdio_oe, a_bin, b_bin;
  logic [31:0] word;
  logic [7:0] m [6];
  logic [7:0] r;
  int n_fail = 0, n_tests = 0;
  wire logic sdio = sdio_oe ? sdio_out : mosi;
  ddc_tuning_format_regs #(.SAMPLE_W(18)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .sen_n(sen_n), .sclk(sclk), .sdio_in(sdio), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .real_decim(real_decim), .sample_a_in(sa), .sample_b_in(sb), .chan_b_tuning_word(word),
    .chan_a_offset_bin(a_bin), .chan_b_offset_bin(b_bin), .sample_a_out(), .sample_b_out());
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    sa <= 18'($urandom);
    sb <= 18'($urandom);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] exp_word();
    return real_decim ? 32'h00000000 : {m[3], m[2], m[1], m[0]};
  endfunction
  // Three low cycles so read data has settled before the rising edge
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d);
    logic [23:0] f;
    f = {rd, a, d};
    sen_n <= 0;
    repeat (2) @(posedge ref_clk);
    for (int i = 23; i >= 0; i--)
    begin
      sclk <= 0;
      mosi <= f[i];
      repeat (3) @(posedge ref_clk);
      r = {r[6:0], sdio};
      sclk <= 1;
      repeat (2) @(posedge ref_clk);
    end
    sclk <= 0;
    repeat (3) @(posedge ref_clk);
    sen_n <= 1;
    @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #2000000;
    n_fail++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(32'h4D91E075));
    foreach (m[i]) m[i] = 8'h00;
    repeat (10) @(posedge ref_clk);
    resetn <= 1;
    @(posedge ref_clk);
    for (int i = 0; i < NUM_REGS; i++)
    begin
      xfer(1, REG_OFS[i], 8'h00);
      chk(32'(r), 32'h00000000);
    end
    $display("reset values done");
    for (int k = 0; k < 5; k++)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        if (i < 4)
          m[i] = (k == 0) ? 8'hFF : 8'($urandom);
        else
          m[i] = {6'h00, (k == 0) | 1'($urandom), 1'b0};
        xfer(0, REG_OFS[i], m[i]);
      end
      chk(word, exp_word());
      chk(32'({a_bin, b_bin}), 32'({m[4][1], m[5][1]}));
      for (int i = 0; i < NUM_REGS; i++)
      begin
        xfer(1, REG_OFS[i], 8'h00);
        chk(32'(r), 32'(m[i]));
      end
    end
    $display("write and read back done");
    xfer(0, 15'h0050, 8'hA5);
    xfer(1, 15'h0050, 8'h00);
    chk(32'(r), 32'h00000000);
    chk(word, exp_word());
    $display("unmapped access done");
    real_decim <= 1;
    repeat (2) @(posedge ref_clk);
    chk(word, 32'h00000000);
    xfer(0, TUNE_B2_OFS, 8'h5A);
    xfer(1, TUNE_B2_OFS, 8'h00);
    chk(32'(r), 32'h00000000);
    for (int i = 0; i < 4; i++) m[i] = 8'h00;
    real_decim <= 0;
    repeat (2) @(posedge ref_clk);
    chk(word, exp_word());
    $display("real decimation done");
    xfer(0, SOFT_RESET_OFS, 8'h01);
    chk(32'({a_bin, b_bin}), 32'h00000000);
    chk(word, 32'h00000000);
    $display("soft reset done");
    print_verdict();
  end
endmodule
